// file: src/reset_seq_defs.svh
// Purpose: Constants for the reset source sequencer.
// Assumes: One clock cycle equals one selected oscillator cycle.
// Notes:   Addresses are byte addresses on the plain register port.
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH

`define CNT_W          13
`define EXT_W          7
// Sequence lengths in oscillator cycles
`define ACTIVE_DRIVE   13'd32
`define INTERNAL_RESET_LINE_TAIL      13'd32
`define VEC_CYCLES     13'd3
`define OSC_STAB       13'd4096
`define SHORT_STOP     13'd32
`define PIN_MIN_LOW    7'd67
`define EXT_INTERNAL_RESET_LINE       7'd64
`define EXT_TOTAL      7'd67
// Register addresses
`define ADDR_CAUSE     16'hfe01
`define ADDR_CONFIG    16'hfe10
`define ADDR_STATUS    16'hfe11
// Reset-cause bit positions
`define CAUSE_PWR      7
`define CAUSE_PIN      6
`define CAUSE_WDOG     5
`define CAUSE_OPC      4
`define CAUSE_ADR      3
`define CAUSE_MON      2
`define CAUSE_BRN      1
`define CAUSE_PWR_VAL  8'h80
// Configuration bits
`define CFG_STOP_EN    1
`define CFG_SHORT_STOP_RECOVERY      0
`define CFG_RESET      8'h00
// Reset vectors
`define VEC_NORMAL     16'hfffe
`define VEC_MONITOR    16'hfefe

`endif

// file: src/reset_seq_pkg.sv
// Purpose: Types shared by the reset source sequencer files.
// Assumes: Constants live in reset_seq_defs.svh.
// Notes:   States carry no fixed codes.
package reset_seq_pkg;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_DRIVE,
      ST_HOLD,
      ST_VEC,
      ST_EXT_LOW,
      ST_EXT_REC,
      ST_STOP,
      ST_STOP_REC
   } seq_state_t;

   typedef logic [12:0] cnt_t;

endpackage : reset_seq_pkg

// file: src/stab_cnt_if.sv
// Purpose: Carries clear and count between sequencer and counter.
// Assumes: Both ends run on the same clock.
// Notes:   None.
`timescale 1ns/1ps
interface stab_cnt_if;
   import reset_seq_pkg::*;

   logic clear;
   cnt_t count;

   modport owner   (output clear, input  count);
   modport counter (input  clear, output count);

endinterface : stab_cnt_if

// file: src/stab_counter.sv
// Purpose: Free-running 13-bit stabilisation counter.
// Assumes: Clock is the selected oscillator clock.
// Notes:   Wraps silently; sequences never need more than 13 bits.
`timescale 1ns/1ps
module stab_counter
   import reset_seq_pkg::*;
(
   // Clock and reset
   input  wire logic  i_sys_clk,
   input  wire logic  i_rst,
   // Counter link
   stab_cnt_if.counter cnt
);

   cnt_t cnt_ff;
   cnt_t nxt_cnt;

   always_comb begin
      if (cnt.clear) begin
         nxt_cnt = '0;
      end else begin
         nxt_cnt = cnt_ff + 13'h1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign cnt.count = cnt_ff;

endmodule : stab_counter

// file: src/reset_source_sequencer.sv
// Purpose: Collects reset sources, drives reset pin and internal reset.
// Assumes: i_sys_clk is the selected oscillator clock.
// Notes:   Pin and watchdog inputs pass through two-flop synchronisers.
`timescale 1ns/1ps
`include "reset_seq_defs.svh"
module reset_source_sequencer
   import reset_seq_pkg::*;
(
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Register port
   input  wire logic [15:0] i_bus_addr,
   input  wire logic [7:0]  i_bus_wdata,
   input  wire logic        i_bus_we,
   input  wire logic        i_bus_re,
   output logic      [7:0]  o_bus_rdata,
   // Reset sources
   input  wire logic        i_power_up_pulse,
   input  wire logic        i_brownout_reset,
   input  wire logic        i_wdog_overflow,
   input  wire logic        i_bad_opcode,
   input  wire logic        i_stop_exec,
   input  wire logic        i_opcode_fetch,
   input  wire logic        i_unmapped_addr,
   input  wire logic        i_monitor_entry_reset,
   // Mode and test voltage sense
   input  wire logic        i_monitor_mode,
   input  wire logic        i_break_state,
   input  wire logic        i_rst_pin_tst,
   input  wire logic        i_irq_pin_tst,
   input  wire logic        i_stop_wake,
   // Open-drain reset pin
   input  wire logic        i_rst_pin,
   output logic             o_rst_pin,
   output logic             o_rst_pin_oe,
   // System controls
   output logic             o_internal_reset_line,
   output logic             o_vector_fetch,
   output logic      [15:0] o_vector_addr,
   output logic             o_clock_gen_output,
   output logic             o_internal_bus_clocks,
   output logic             o_wdog_disable
);

   stab_cnt_if cnt_link ();

   stab_counter u_stab_counter (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .cnt       (cnt_link.counter)
   );

   // Synchronisers for asynchronous inputs
   logic [1:0] pin_sync_ff;
   logic [1:0] wdog_sync_ff;
   logic [1:0] nxt_pin_sync;
   logic [1:0] nxt_wdog_sync;

   always_comb begin
      nxt_pin_sync  = {pin_sync_ff[0], i_rst_pin};
      nxt_wdog_sync = {wdog_sync_ff[0], i_wdog_overflow};
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         pin_sync_ff  <= 2'h3;
         wdog_sync_ff <= 2'h0;
      end else begin
         pin_sync_ff  <= nxt_pin_sync;
         wdog_sync_ff <= nxt_wdog_sync;
      end
   end

   function automatic logic cnt_hit(input cnt_t c, input cnt_t len);
      cnt_hit = (c == cnt_t'(len - 13'h1));
   endfunction : cnt_hit

   // Sequencer state
   seq_state_t       state_ff;
   seq_state_t       nxt_state;
   logic             long_ff;
   logic             nxt_long;
   logic [6:0]       ext_cnt_ff;
   logic [6:0]       nxt_ext_cnt;
   logic [7:0]       cause_ff;
   logic [7:0]       nxt_cause;
   logic [7:0]       cfg_ff;
   logic [7:0]       nxt_cfg;
   logic [2:0]       oe_hist_ff;
   logic [2:0]       nxt_oe_hist;

   logic             wdog_dis;
   logic             src_wdog;
   logic             src_opc;
   logic             src_adr;
   logic             src_long;
   logic             src_short;
   logic             in_active;
   logic             pin_low;
   cnt_t             drive_len;
   cnt_t             stop_len;

   always_comb begin
      wdog_dis  = (i_monitor_mode & (i_rst_pin_tst | i_irq_pin_tst))
                | (i_break_state & i_rst_pin_tst);
      src_wdog  = wdog_sync_ff[1] & ~wdog_dis;
      src_opc   = i_bad_opcode
                | (i_stop_exec & ~cfg_ff[`CFG_STOP_EN]);
      src_adr   = i_opcode_fetch & i_unmapped_addr;
      src_long  = i_power_up_pulse | i_brownout_reset;
      src_short = src_wdog | src_opc | src_adr
                | i_monitor_entry_reset;
      in_active = (state_ff == ST_DRIVE) | (state_ff == ST_HOLD);
      // Own drive echoes through the synchroniser, so mask its tail
      pin_low   = ~pin_sync_ff[1] & ~(|oe_hist_ff);
      drive_len = long_ff ? (`OSC_STAB + `ACTIVE_DRIVE)
                          : `ACTIVE_DRIVE;
      stop_len  = cfg_ff[`CFG_SHORT_STOP_RECOVERY] ? `SHORT_STOP
                                     : `OSC_STAB;
   end

   always_comb begin
      nxt_state     = state_ff;
      nxt_long      = long_ff;
      nxt_ext_cnt   = ext_cnt_ff;
      nxt_cause     = cause_ff;
      cnt_link.clear = 1'b0;
      if (src_long) begin
         nxt_state      = ST_DRIVE;
         nxt_long       = 1'b1;
         cnt_link.clear = 1'b1;
         if (i_power_up_pulse) begin
            nxt_cause = `CAUSE_PWR_VAL;
         end
         nxt_cause[`CAUSE_BRN] = i_brownout_reset
                               | nxt_cause[`CAUSE_BRN];
      end else if (src_short && !in_active) begin
         nxt_state      = ST_DRIVE;
         nxt_long       = 1'b0;
         cnt_link.clear = 1'b1;
         nxt_cause[`CAUSE_WDOG] = cause_ff[`CAUSE_WDOG] | src_wdog;
         nxt_cause[`CAUSE_OPC]  = cause_ff[`CAUSE_OPC] | src_opc;
         nxt_cause[`CAUSE_ADR]  = cause_ff[`CAUSE_ADR] | src_adr;
         nxt_cause[`CAUSE_MON]  = cause_ff[`CAUSE_MON]
                                | i_monitor_entry_reset;
      end else if (pin_low && !in_active &&
                   state_ff != ST_EXT_LOW) begin
         nxt_state   = ST_EXT_LOW;
         nxt_long    = 1'b0;
         nxt_ext_cnt = 7'h1;
      end else begin
         case (state_ff)
            ST_RUN: begin
               if (i_stop_exec && cfg_ff[`CFG_STOP_EN]) begin
                  nxt_state      = ST_STOP;
                  cnt_link.clear = 1'b1;
               end
            end
            ST_DRIVE: begin
               if (cnt_hit(cnt_link.count, drive_len)) begin
                  nxt_state = ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt_hit(cnt_link.count,
                           cnt_t'(drive_len + `INTERNAL_RESET_LINE_TAIL))) begin
                  nxt_state = ST_VEC;
               end
            end
            ST_VEC: begin
               if (cnt_hit(cnt_link.count, cnt_t'(drive_len +
                           `INTERNAL_RESET_LINE_TAIL + `VEC_CYCLES))) begin
                  nxt_state = ST_RUN;
                  nxt_long  = 1'b0;
               end
            end
            ST_EXT_LOW: begin
               if (ext_cnt_ff != `PIN_MIN_LOW) begin
                  nxt_ext_cnt = ext_cnt_ff + 7'h1;
               end else begin
                  nxt_cause[`CAUSE_PIN] = 1'b1;
               end
               if (!pin_low) begin
                  nxt_state   = ST_EXT_REC;
                  nxt_ext_cnt = 7'h0;
               end
            end
            ST_EXT_REC: begin
               nxt_ext_cnt = ext_cnt_ff + 7'h1;
               if (ext_cnt_ff == `EXT_TOTAL - 7'h1) begin
                  nxt_state = ST_RUN;
               end
            end
            ST_STOP: begin
               if (i_stop_wake) begin
                  nxt_state      = ST_STOP_REC;
                  cnt_link.clear = 1'b1;
               end
            end
            ST_STOP_REC: begin
               if (cnt_hit(cnt_link.count, stop_len)) begin
                  nxt_state = ST_RUN;
               end
            end
            default: begin
               nxt_state = ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_ff   <= ST_DRIVE;
         long_ff    <= 1'b1;
         ext_cnt_ff <= 7'h0;
         cause_ff   <= `CAUSE_PWR_VAL;
      end else begin
         state_ff   <= nxt_state;
         long_ff    <= nxt_long;
         ext_cnt_ff <= nxt_ext_cnt;
         cause_ff   <= nxt_cause;
      end
   end

   // Output decode, registered from next state
   logic        internal_reset_line_ff;
   logic        nxt_internal_reset_line;
   logic        drive_ff;
   logic        nxt_drive;
   logic        vfetch_ff;
   logic        nxt_vfetch;
   logic        busclk_ff;
   logic        nxt_busclk;
   logic        cgout_ff;
   logic        nxt_cgout;
   logic [15:0] vec_ff;
   logic [15:0] nxt_vec;
   logic [7:0]  rdata_ff;
   logic [7:0]  nxt_rdata;

   always_comb begin
      nxt_drive  = (nxt_state == ST_DRIVE);
      nxt_internal_reset_line   = nxt_drive | (nxt_state == ST_HOLD)
                 | (nxt_state == ST_EXT_LOW)
                 | ((nxt_state == ST_EXT_REC)
                    && (nxt_ext_cnt < `EXT_INTERNAL_RESET_LINE));
      nxt_vfetch = (nxt_state == ST_VEC)
                 | ((nxt_state == ST_EXT_REC)
                    && (nxt_ext_cnt >= `EXT_INTERNAL_RESET_LINE));
      nxt_vec    = i_monitor_mode ? `VEC_MONITOR
                                  : `VEC_NORMAL;
      nxt_busclk = !((nxt_state == ST_STOP)
                  || (nxt_state == ST_STOP_REC)
                  || (nxt_state == ST_EXT_LOW)
                  || (nxt_drive && nxt_long
                      && (cnt_link.count < `OSC_STAB - 13'h1))
                  || cnt_link.clear && nxt_long);
      nxt_cgout  = (nxt_state != ST_STOP);
      nxt_oe_hist = {oe_hist_ff[1:0], drive_ff};
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         internal_reset_line_ff    <= 1'b1;
         drive_ff   <= 1'b1;
         vfetch_ff  <= 1'b0;
         busclk_ff  <= 1'b0;
         cgout_ff   <= 1'b1;
         vec_ff     <= `VEC_NORMAL;
         oe_hist_ff <= 3'h7;
      end else begin
         internal_reset_line_ff    <= nxt_internal_reset_line;
         drive_ff   <= nxt_drive;
         vfetch_ff  <= nxt_vfetch;
         busclk_ff  <= nxt_busclk;
         cgout_ff   <= nxt_cgout;
         vec_ff     <= nxt_vec;
         oe_hist_ff <= nxt_oe_hist;
      end
   end

   // Configuration and read port; config returns to default on
   // internal reset so a stale stop setting cannot survive
   always_comb begin
      nxt_cfg = cfg_ff;
      if (internal_reset_line_ff) begin
         nxt_cfg = `CFG_RESET;
      end else if (i_bus_we && i_bus_addr == `ADDR_CONFIG) begin
         nxt_cfg = {6'h0, i_bus_wdata[1:0]};
      end
      nxt_rdata = 8'h0;
      if (i_bus_re) begin
         case (i_bus_addr)
            `ADDR_CAUSE:  nxt_rdata = {cause_ff[7:1], 1'b0};
            `ADDR_CONFIG: nxt_rdata = cfg_ff;
            `ADDR_STATUS: nxt_rdata = {3'h0, wdog_dis, busclk_ff,
                                       vfetch_ff, drive_ff, internal_reset_line_ff};
            default:      nxt_rdata = 8'h0;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         cfg_ff   <= `CFG_RESET;
         rdata_ff <= 8'h0;
      end else begin
         cfg_ff   <= nxt_cfg;
         rdata_ff <= nxt_rdata;
      end
   end

   assign o_bus_rdata           = rdata_ff;
   assign o_rst_pin             = 1'b0;
   assign o_rst_pin_oe          = drive_ff;
   assign o_internal_reset_line = internal_reset_line_ff;
   assign o_vector_fetch        = vfetch_ff;
   assign o_vector_addr         = vec_ff;
   assign o_clock_gen_output    = cgout_ff;
   assign o_internal_bus_clocks = busclk_ff;
   assign o_wdog_disable        = wdog_dis;

endmodule : reset_source_sequencer

// file: test/reset_pin_partner.sv
// Purpose: Other chips sharing the open-drain reset line.
// Assumes: The line has a pull-up; anyone may pull it low at any time.
// Notes:   Pull timing is commanded by the bench.
`timescale 1ns/1ps
module reset_pin_partner (
   // Drivers of the shared line
   input  wire logic i_dut_oe,
   input  wire logic i_dut_pin,
   input  wire logic i_pull_low,
   // Resolved line level
   output logic      o_line
);
   // Released line goes to the pull-up level, never a stale value
   assign o_line = (i_pull_low || (i_dut_oe && !i_dut_pin)) ?
                   1'b0 : 1'b1;
endmodule : reset_pin_partner

// file: test/reset_source_sequencer_props.sv
// Purpose: Timing checks on the reset sequencer outputs.
// Assumes: One clock domain; reset synchronous, active high.
// Notes:   Drive after i_rst release may count one cycle more.
`timescale 1ns/1ps
`include "reset_seq_defs.svh"
module reset_source_sequencer_props (
   // Clock and reset
   input wire logic        i_sys_clk,
   input wire logic        i_rst,
   // Mode and test voltage
   input wire logic        i_monitor_mode,
   input wire logic        i_break_state,
   input wire logic        i_rst_pin_tst,
   input wire logic        i_irq_pin_tst,
   // Watched outputs
   input wire logic        o_rst_pin,
   input wire logic        o_rst_pin_oe,
   input wire logic        o_internal_reset_line,
   input wire logic        o_vector_fetch,
   input wire logic [15:0] o_vector_addr,
   input wire logic        o_clock_gen_output,
   input wire logic        o_internal_bus_clocks,
   input wire logic        o_wdog_disable
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   logic [12:0] oe_len_ff;
   logic [12:0] nxt_oe_len;
   always_comb begin
      nxt_oe_len = (i_rst || !o_rst_pin_oe) ? 13'h0 : oe_len_ff + 13'h1;
   end
   always_ff @(posedge i_sys_clk) begin
      oe_len_ff <= nxt_oe_len;
   end
   sequence tail_s;
      o_internal_reset_line [*8] ##24 o_internal_reset_line
         ##1 !o_internal_reset_line;
   endsequence
   sequence vec_s;
      o_vector_fetch [*3] ##1 !o_vector_fetch;
   endsequence
   a_oe_needs_internal_reset_line: assert property (o_rst_pin_oe |-> o_internal_reset_line)
      else $error("pin driven without internal reset");
   a_pin_drives_low: assert property (o_rst_pin_oe |-> !o_rst_pin)
      else $error("pin driven high");
   a_drive_len: assert property ($fell(o_rst_pin_oe) |->
      oe_len_ff inside {13'd32, 13'd4128, 13'd4129})
      else $error("pin drive length wrong");
   a_internal_reset_line_tail: assert property ($fell(o_rst_pin_oe) |-> tail_s)
      else $error("internal reset tail wrong");
   a_vec_window: assert property ($fell(o_internal_reset_line) |-> vec_s)
      else $error("vector window wrong");
   a_vec_addr: assert property (o_vector_fetch && $stable(i_monitor_mode)
      |-> o_vector_addr == (i_monitor_mode ? `VEC_MONITOR : `VEC_NORMAL))
      else $error("vector address wrong");
   a_wdog_comb: assert property (o_wdog_disable ==
      ((i_monitor_mode && (i_rst_pin_tst || i_irq_pin_tst)) ||
       (i_break_state && i_rst_pin_tst)))
      else $error("watchdog disable wrong");
   a_busclk_late: assert property ($rose(o_internal_bus_clocks) &&
      o_rst_pin_oe |-> oe_len_ff >= 13'd4096)
      else $error("bus clocks started early");
   a_cgout_on: assert property (o_rst_pin_oe |-> o_clock_gen_output)
      else $error("clock output off during reset drive");
endmodule : reset_source_sequencer_props
bind reset_source_sequencer reset_source_sequencer_props chk_u (
   .i_sys_clk, .i_rst, .i_monitor_mode, .i_break_state, .i_rst_pin_tst,
   .i_irq_pin_tst, .o_rst_pin, .o_rst_pin_oe, .o_internal_reset_line,
   .o_vector_fetch, .o_vector_addr, .o_clock_gen_output,
   .o_internal_bus_clocks, .o_wdog_disable);

// file: test/testbench.sv
// Purpose: Self-checking bench for the reset source sequencer.
// Assumes: One clock cycle is one oscillator cycle.
// Notes:   Wake latency allows a few cycles of pipeline slack.
`timescale 1ns/1ps
`include "reset_seq_defs.svh"
module testbench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] bus_addr = 16'h0;
   logic [7:0]  wdata = 8'h0;
   logic        we = 1'b0;
   logic        re = 1'b0;
   logic [8:0]  src = 9'h0;
   logic [3:0]  modes = 4'h0;
   logic        pull = 1'b0;
   logic [7:0]  rdata, exp_cause, rv;
   logic [15:0] vaddr;
   logic        pin, pin_o, oe, internal_reset_line, vf, cgo, bclk, wdis;
   int          mismatches = 0;
   int          checks = 0;
   int          n, t, off, i;
   logic [8:0]  mask_t [5] = '{9'h008, 9'h004, 9'h010, 9'h060, 9'h080};
   logic [7:0]  flag_t [5] = '{8'h10, 8'h20, 8'h10, 8'h08, 8'h04};
   always #10 clk = ~clk;
   reset_source_sequencer dut_u (
      .i_sys_clk(clk), .i_rst(rst), .i_bus_addr(bus_addr),
      .i_bus_wdata(wdata), .i_bus_we(we), .i_bus_re(re),
      .o_bus_rdata(rdata), .i_power_up_pulse(src[0]),
      .i_brownout_reset(src[1]), .i_wdog_overflow(src[2]),
      .i_bad_opcode(src[3]), .i_stop_exec(src[4]),
      .i_opcode_fetch(src[5]), .i_unmapped_addr(src[6]),
      .i_monitor_entry_reset(src[7]), .i_monitor_mode(modes[3]),
      .i_break_state(modes[2]), .i_rst_pin_tst(modes[1]),
      .i_irq_pin_tst(modes[0]), .i_stop_wake(src[8]), .i_rst_pin(pin),
      .o_rst_pin(pin_o), .o_rst_pin_oe(oe), .o_internal_reset_line(internal_reset_line),
      .o_vector_fetch(vf), .o_vector_addr(vaddr),
      .o_clock_gen_output(cgo), .o_internal_bus_clocks(bclk),
      .o_wdog_disable(wdis));
   reset_pin_partner peer_u (.i_dut_oe(oe), .i_dut_pin(pin_o),
      .i_pull_low(pull), .o_line(pin));
   function automatic logic exp_wdis(input logic [3:0] m);
      return (m[3] && (m[1] || m[0])) || (m[2] && m[1]);
   endfunction : exp_wdis
   task report_and_stop;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   task tmo;
      mismatches++;
      report_and_stop();
   endtask : tmo
   task chk_val(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val
   task chk_cnt(input int got, input int exp);
      checks++;
      if (got != exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_cnt
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd
   task fire(input logic [8:0] m);
      @(posedge clk);
      src <= m;
      @(posedge clk);
      src <= 9'h0;
      @(negedge clk);
   endtask : fire
   task wait_done;
      t = 0;
      while ((internal_reset_line !== 1'b0 || vf !== 1'b0) && t < 6000) begin
         @(negedge clk);
         t++;
      end
      if (t >= 6000) tmo();
   endtask : wait_done
   task quiet;
      n = 0;
      repeat (12) @(negedge clk) n += (internal_reset_line === 1'b1);
      chk_cnt(n, 0);
   endtask : quiet
   task measure(input int eo, input int ei, input logic [15:0] va);
      int no, ni, nv;
      no = 0;
      ni = 0;
      nv = 0;
      t = 0;
      while (oe !== 1'b1 && t < 20) begin
         @(negedge clk);
         t++;
      end
      while (internal_reset_line === 1'b1 && ni < 5000) begin
         no += (oe === 1'b1);
         ni++;
         @(negedge clk);
      end
      while (vf === 1'b1 && nv < 9) begin
         chk_val(vaddr, va);
         nv++;
         @(negedge clk);
      end
      if (t >= 20 || ni >= 5000 || nv >= 9) tmo();
      chk_cnt(no, eo);
      chk_cnt(ni, ei);
      chk_cnt(nv, 3);
   endtask : measure
   task wake_time(input int lo);
      fire(9'h100);
      n = 0;
      while (bclk !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 5000) tmo();
      chk_cnt(int'(n >= lo && n <= lo + 3), 1);
   endtask : wake_time
   initial begin
      #2000000;
      tmo();
   end
   initial begin
      void'($urandom(32'h6ffbe4bf));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wait_done();
      exp_cause = `CAUSE_PWR_VAL;
      rd(`ADDR_CAUSE, rv);
      chk_val(rv, exp_cause);
      wr(`ADDR_CAUSE, 8'hff);
      rd(`ADDR_CAUSE, rv);
      chk_val(rv, exp_cause);
      rd(16'hfe20, rv);
      chk_val(rv, 8'h00);
      rd(`ADDR_STATUS, rv);
      chk_val(rv, 8'h08);
      n = $urandom;
      wr(`ADDR_CONFIG, n[7:0]);
      rd(`ADDR_CONFIG, rv);
      chk_val(rv, {6'h0, n[1:0]});
      wr(`ADDR_CONFIG, 8'h00);
      fire(9'h040);
      quiet();
      fire(9'h020);
      quiet();
      off = $urandom % 5;
      for (int k = 0; k < 5; k++) begin
         i = (k + off) % 5;
         @(posedge clk);
         modes <= {i == 4, 3'b000};
         fire(mask_t[i]);
         exp_cause |= flag_t[i];
         measure(32, 64, (i == 4) ? `VEC_MONITOR : `VEC_NORMAL);
         rd(`ADDR_CAUSE, rv);
         chk_val(rv, exp_cause);
      end
      for (int c = 0; c < 24; c++) begin
         n = (c < 16) ? c : $urandom;
         @(posedge clk);
         modes <= n[3:0];
         @(negedge clk);
         chk_val(wdis, exp_wdis(n[3:0]));
      end
      @(posedge clk);
      modes <= 4'b1010;
      fire(9'h004);
      quiet();
      @(posedge clk);
      modes <= 4'h0;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         pull <= 1'b1;
         repeat (p ? 72 + $urandom % 30 : 20) @(posedge clk);
         pull <= 1'b0;
         @(negedge clk);
         chk_val({internal_reset_line, oe}, 2'b10);
         wait_done();
         if (p) exp_cause |= 8'h40;
         rd(`ADDR_CAUSE, rv);
         chk_val(rv, exp_cause);
      end
      for (int p = 0; p < 2; p++) begin
         wr(`ADDR_CONFIG, p ? 8'h02 : 8'h03);
         fire(9'h010);
         repeat (3) @(negedge clk);
         chk_val({bclk, cgo, internal_reset_line}, 3'b000);
         wake_time(p ? int'(`OSC_STAB) : int'(`SHORT_STOP));
      end
      for (int p = 0; p < 2; p++) begin
         fire(p ? 9'h002 : 9'h001);
         measure(4128, 4160, `VEC_NORMAL);
         exp_cause = p ? exp_cause | 8'h02 : `CAUSE_PWR_VAL;
         rd(`ADDR_CAUSE, rv);
         chk_val(rv, exp_cause);
         rd(`ADDR_CONFIG, rv);
         chk_val(rv, `CFG_RESET);
      end
      report_and_stop();
   end
endmodule : testbench
